// ### rtl/pmrs_defs.svh
// offsets, field positions, reset values and timing counts of the sequencer
// assumes a 40 MHz pclk and a 32-bit APB register bus
`ifndef PMRS_DEFS_SVH
`define PMRS_DEFS_SVH
`define PMRS_OFF_MODE     12'h000
`define PMRS_OFF_SRST     12'h004
`define PMRS_OFF_DOM      12'h008
`define PMRS_OFF_CMD      12'h00C
`define PMRS_OFF_SLPT     12'h010
`define PMRS_OFF_THR      12'h014
`define PMRS_OFF_STAT     12'h018
`define PMRS_MODE_LFX_LSB 0
`define PMRS_MODE_SLPDIS  2
`define PMRS_MODE_XREQ    3
`define PMRS_MODE_VCCCHG  4
`define PMRS_MODE_SRC     5
`define PMRS_MODE_CAL     6
`define PMRS_MODE_RST     7'h50
`define PMRS_DOM_RADIO    0
`define PMRS_DOM_IRAM0    1
`define PMRS_DOM_IRAM1    2
`define PMRS_DOM_DRAM1    3
`define PMRS_DOM_OTP      4
`define PMRS_DOM_RST      5'h00
`define PMRS_CMD_HALT     0
`define PMRS_CMD_SLEEP    1
`define PMRS_CMD_DEEP     2
`define PMRS_THR_RST      8'h20
`define PMRS_SLPT_RST     32'h00000000
`define PMRS_STAT_CFG_LSB 3
`define PMRS_STAT_LV_LSB  5
`define PMRS_STAT_RF      8
`define PMRS_STAT_KEY     9
`define PMRS_STAT_RST     10
`define PMRS_KEY_FIRST    32'hCAFEABAB
`define PMRS_KEY_SECOND   32'hCDCDBEEF
`define PMRS_CLK_MHZ      40
`define PMRS_RST_HOLD_NS  1000
`define PMRS_RST_HOLD_CYC ((`PMRS_RST_HOLD_NS * `PMRS_CLK_MHZ + 999) / 1000)
`define PMRS_MIN_SLEEP_US 100
`define PMRS_MIN_SLEEP_CYC (`PMRS_MIN_SLEEP_US * `PMRS_CLK_MHZ)
`endif

// ### rtl/pmrs_pkg.sv
// types shared by the power mode and reset sequencer
// assumes nothing beyond the defs header
package pmrs_pkg;
	typedef enum logic [2:0] {
		ST_DETECT,
		ST_ACTIVE_RC,
		ST_ACTIVE_XTAL,
		ST_HALT,
		ST_SLEEP,
		ST_DEEP,
		ST_DISABLE
	} pmrs_state_type;
	typedef enum logic [1:0] {
		CFG_STEP_DOWN,
		CFG_STEP_UP,
		CFG_DCDC_OFF,
		CFG_EXT_DCDC
	} pmrs_cfg_type;
endpackage : pmrs_pkg

// ### rtl/pmrs_top.sv
// power mode and reset sequencer with its APB register file
// assumes analog comparators and pads arrive asynchronously; presetn is the power-on reset
// What this block does
// [RULE_01] enable pin low: disable mode, pads hi-z, registers lost, firmware held in reset
// [RULE_02] power-on reset loads every flop of the block with its reset value
// [RULE_03] core and radio reset by power-on, supply check, watchdog or soft reset
// [RULE_04] two key words written in order fire the soft reset
// [RULE_05] always-on domain enable stays high permanently
// [RULE_06] sequencer switches retention and minimal domains; cpu bits switch the rest
// [RULE_07] radio, second instruction ram and otp need the minimal domain on
// [RULE_08] supply configuration detected at start, regulation follows it
// [RULE_09] a monitored supply going low raises a low-voltage event
// [RULE_10] battery-side monitor takes a 4-bit threshold code, 100mV steps
// [RULE_11] core supply monitor takes a 4-bit code, 50mV steps, 0010 is 1.05V
// [RULE_12] radio supply level bit readable by firmware
// [RULE_13] power-up, enable release or wake enter active rc mode
// [RULE_14] crystal request moves active rc to active crystal mode
// [RULE_15] idle cpu halts; sleep only when enough time remains
// [RULE_16] sleep disabled by software keeps the halted active state
// [RULE_17] sleep ends on sleep timer expiry or pad activity
// [RULE_18] deep sleep only on command; no vcc charge, low-precision rc
// [RULE_19] sleep modes: dcdc off, cpu off, bank zero retained, slow clock
// [RULE_20] low-frequency rc runs always, relaxed when crystal times sleep
// [RULE_21] crystal mode 0 off with clock at zero, 1 crystal, 2 square, 3 sine
// [RULE_22] reset default sleep source is internal rc with calibration on
// [RULE_23] state machine drives clock choice and enables; disable overrides all
`timescale 1ns/1ps
`include "pmrs_defs.svh"
module pmrs_top import pmrs_pkg::*; (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// pads and comparators, asynchronous
	input  wire logic        chip_enable_pin,
	input  wire logic        wake_pad,
	input  wire logic        vdd_low_cmp,
	input  wire logic        battery_side_supply_below,
	input  wire logic        vcc_below,
	input  wire logic        rf_supply_ok,
	input  wire logic        det_battery_side_supply_hi,
	input  wire logic        det_vcc_hi,
	input  wire logic        det_sw_grounded,
	input  wire logic        lowfreq_osc_input,
	input  wire logic        lowfreq_amp_out,
	// cpu side, same clock
	input  wire logic        watchdog_req,
	// resets and pads
	output logic             core_reset_n,
	output logic             gpio_hiz,
	// power domains
	output logic             always_on_domain_en,
	output logic             retention_ram_domain_en,
	output logic             cpu_minimal_domain_en,
	output logic             radio_domain_en,
	output logic             iram0_domain_en,
	output logic             iram1_domain_en,
	output logic             dram1_domain_en,
	output logic             otp_domain_en,
	output logic             data_ram_bank_zero_retain,
	// regulation and monitors
	output logic             dcdc_en,
	output logic             dcdc_step_up,
	output logic             dcdc_switch,
	output logic             ldo_vcc_en,
	output logic             vcc_charge_en,
	output logic      [3:0]  battery_side_supply_thresh_code,
	output logic      [3:0]  vcc_thresh_code,
	output logic             lowvolt_event,
	// clocks and cpu
	output logic             sysclk_sel_xtal,
	output logic             hf_xtal_en,
	output logic             pm_clk_slow,
	output logic             lfrc_low_precision,
	output logic             lfrc_calib_en,
	output logic             lfx_amp_en,
	output logic             lfx_load_cap_en,
	output logic             lowfreq_crystal_clock,
	output logic             cpu_halt
);

	pmrs_state_type state;
	pmrs_state_type next_state;
	pmrs_cfg_type   cfg;
	logic [10:0]    sync1;
	logic [10:0]    sync2;
	logic           en_s;
	logic           wake_s;
	logic           vdd_low_s;
	logic           battery_side_supply_low_s;
	logic           vcc_low_s;
	logic           rf_ok_s;
	logic           det_battery_side_supply_s;
	logic           det_vcc_s;
	logic           det_sw_s;
	logic           osc_in_s;
	logic           amp_out_s;
	logic [6:0]     mode_reg;
	logic [4:0]     dom_reg;
	logic [7:0]     thr_reg;
	logic [31:0]    slp_time;
	logic [31:0]    slp_cnt;
	logic [1:0]     cmd_pend;
	logic [2:0]     lv_prev;
	logic [2:0]     lv_flags;
	logic [2:0]     lv_rise;
	logic           key_armed;
	logic           soft_fire;
	logic [5:0]     rst_cnt;
	logic [1:0]     det_cnt;
	logic [31:0]    rd_mux;
	logic           mapped;
	logic           setup;
	logic           wr;
	logic           halt_cmd;
	logic           time_ok;
	logic           rst_cause;
	logic           next_sleeping;
	logic           next_cpu_on;
	logic [1:0]     lfx_mode;
	logic           src_lfx;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction

	function automatic pmrs_cfg_type decode_cfg(input logic vb1, input logic vcc,
		input logic swg);
		if (swg)
			return vcc ? CFG_EXT_DCDC : CFG_DCDC_OFF;
		return vb1 ? CFG_STEP_DOWN : CFG_STEP_UP;
	endfunction

	// two-flop synchronisers for every pad and comparator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 11'h000;
			sync2 <= 11'h000;
		end else begin
			sync1 <= {chip_enable_pin, wake_pad, vdd_low_cmp, battery_side_supply_below, vcc_below,
				rf_supply_ok, det_battery_side_supply_hi, det_vcc_hi, det_sw_grounded,
				lowfreq_osc_input, lowfreq_amp_out};
			sync2 <= sync1;
		end
	end
	assign {en_s, wake_s, vdd_low_s, battery_side_supply_low_s, vcc_low_s, rf_ok_s, det_battery_side_supply_s,
		det_vcc_s, det_sw_s, osc_in_s, amp_out_s} = sync2;

	// apb decode
	assign setup    = psel & ~penable;
	assign wr       = psel & penable & pready & pwrite;
	assign halt_cmd = wr & hit(paddr, `PMRS_OFF_CMD) & pwdata[`PMRS_CMD_HALT];
	assign mapped   = hit(paddr, `PMRS_OFF_MODE) | hit(paddr, `PMRS_OFF_SRST)
		| hit(paddr, `PMRS_OFF_DOM) | hit(paddr, `PMRS_OFF_CMD)
		| hit(paddr, `PMRS_OFF_SLPT) | hit(paddr, `PMRS_OFF_THR)
		| hit(paddr, `PMRS_OFF_STAT);

	always_comb begin
		rd_mux = 32'h00000000;
		if (hit(paddr, `PMRS_OFF_MODE))
			rd_mux[6:0] = mode_reg;
		if (hit(paddr, `PMRS_OFF_DOM))
			rd_mux[4:0] = dom_reg;
		if (hit(paddr, `PMRS_OFF_SLPT))
			rd_mux = slp_time;
		if (hit(paddr, `PMRS_OFF_THR))
			rd_mux[7:0] = thr_reg;
		if (hit(paddr, `PMRS_OFF_STAT)) begin
			rd_mux[2:0] = state;
			rd_mux[`PMRS_STAT_CFG_LSB +: 2] = cfg;
			rd_mux[`PMRS_STAT_LV_LSB +: 3] = lv_flags;
			rd_mux[`PMRS_STAT_RF] = rf_ok_s; // [RULE_12]
			rd_mux[`PMRS_STAT_KEY] = key_armed;
			rd_mux[`PMRS_STAT_RST] = ~core_reset_n;
		end
	end

	// no wait state: answer prepared in setup, pready high in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			if (setup & ~pwrite)
				prdata <= rd_mux;
		end
	end

	// control registers, lost while disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= `PMRS_MODE_RST; // [RULE_22]
			dom_reg  <= `PMRS_DOM_RST;
			thr_reg  <= `PMRS_THR_RST;
			slp_time <= `PMRS_SLPT_RST;
		end else if (state == ST_DISABLE) begin
			mode_reg <= `PMRS_MODE_RST; // [RULE_01]
			dom_reg  <= `PMRS_DOM_RST;
			thr_reg  <= `PMRS_THR_RST;
			slp_time <= `PMRS_SLPT_RST;
		end else if (wr) begin
			if (hit(paddr, `PMRS_OFF_MODE))
				mode_reg <= pwdata[6:0];
			if (hit(paddr, `PMRS_OFF_DOM))
				dom_reg <= pwdata[4:0]; // [RULE_06]
			if (hit(paddr, `PMRS_OFF_THR))
				thr_reg <= pwdata[7:0]; // [RULE_10] [RULE_11]
			if (hit(paddr, `PMRS_OFF_SLPT))
				slp_time <= pwdata;
		end
	end
	assign lfx_mode = mode_reg[`PMRS_MODE_LFX_LSB +: 2];
	assign src_lfx  = mode_reg[`PMRS_MODE_SRC] & (lfx_mode != 2'h0);
	assign time_ok  = slp_time >= 32'(`PMRS_MIN_SLEEP_CYC);

	// soft reset key: first word arms, second word fires, anything else disarms
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_armed <= 1'b0;
			soft_fire <= 1'b0;
		end else begin
			soft_fire <= 1'b0;
			if (state == ST_DISABLE) begin
				key_armed <= 1'b0;
			end else if (wr & hit(paddr, `PMRS_OFF_SRST)) begin
				key_armed <= pwdata == `PMRS_KEY_FIRST; // [RULE_04]
				soft_fire <= key_armed & (pwdata == `PMRS_KEY_SECOND); // [RULE_04]
			end
		end
	end

	// core and radio reset stretcher
	assign rst_cause = soft_fire | watchdog_req | vdd_low_s | (state == ST_DISABLE);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_cnt      <= 6'(`PMRS_RST_HOLD_CYC); // [RULE_02]
			core_reset_n <= 1'b0;
		end else begin
			if (rst_cause)
				rst_cnt <= 6'(`PMRS_RST_HOLD_CYC); // [RULE_03]
			else if (rst_cnt != 6'h00)
				rst_cnt <= rst_cnt - 6'h01;
			core_reset_n <= ~rst_cause & (rst_cnt <= 6'h01); // [RULE_03]
		end
	end

	// low-voltage events, set wins over write-one clear
	assign lv_rise = {~rf_ok_s, vcc_low_s, battery_side_supply_low_s} & ~lv_prev;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lv_prev       <= 3'h4; // matches the synchroniser's reset image of rf ok
			lv_flags      <= 3'h0;
			lowvolt_event <= 1'b0;
		end else begin
			lv_prev       <= {~rf_ok_s, vcc_low_s, battery_side_supply_low_s};
			lowvolt_event <= |lv_rise; // [RULE_09]
			if (wr & hit(paddr, `PMRS_OFF_STAT))
				lv_flags <= (lv_flags & ~pwdata[`PMRS_STAT_LV_LSB +: 3]) | lv_rise;
			else
				lv_flags <= lv_flags | lv_rise; // [RULE_09]
		end
	end

	// mode sequencer
	always_comb begin
		next_state = state;
		unique case (state)
			ST_DETECT:
				if (det_cnt == 2'h3)
					next_state = ST_ACTIVE_RC; // [RULE_13]
			ST_ACTIVE_RC:
				if (halt_cmd)
					next_state = ST_HALT; // [RULE_15]
				else if (mode_reg[`PMRS_MODE_XREQ])
					next_state = ST_ACTIVE_XTAL; // [RULE_14]
			ST_ACTIVE_XTAL:
				if (halt_cmd)
					next_state = ST_HALT;
				else if (!mode_reg[`PMRS_MODE_XREQ])
					next_state = ST_ACTIVE_RC;
			ST_HALT:
				if (wake_s)
					next_state = ST_ACTIVE_RC;
				else if (mode_reg[`PMRS_MODE_SLPDIS])
					next_state = ST_HALT; // [RULE_16]
				else if (cmd_pend[1])
					next_state = ST_DEEP; // [RULE_18]
				else if (cmd_pend[0] & time_ok)
					next_state = ST_SLEEP; // [RULE_15]
			ST_SLEEP:
				if (wake_s | (slp_cnt == 32'h00000000))
					next_state = ST_ACTIVE_RC; // [RULE_17]
			ST_DEEP:
				if (wake_s | ((slp_cnt == 32'h00000000) & (slp_time != 32'h00000000)))
					next_state = ST_ACTIVE_RC; // [RULE_17]
			ST_DISABLE:
				if (en_s)
					next_state = ST_ACTIVE_RC; // [RULE_13]
			default:
				next_state = ST_DISABLE;
		endcase
		if (!en_s)
			next_state = ST_DISABLE; // [RULE_01] [RULE_23]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= ST_DETECT; // [RULE_02]
		else
			state <= next_state;
	end

	// configuration follows the detector while in the detect or disable state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_cnt <= 2'h0;
			cfg     <= CFG_STEP_DOWN;
		end else if ((state == ST_DETECT) | (state == ST_DISABLE)) begin
			det_cnt <= det_cnt + 2'h1;
			cfg     <= decode_cfg(det_battery_side_supply_s, det_vcc_s, det_sw_s); // [RULE_08]
		end
	end

	// halt command carries the pending sleep request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cmd_pend <= 2'h0;
		else if (halt_cmd)
			cmd_pend <= {pwdata[`PMRS_CMD_DEEP], pwdata[`PMRS_CMD_SLEEP]};
		else if (next_state != ST_HALT)
			cmd_pend <= 2'h0;
	end

	// sleep timer loaded on entry, counts down while asleep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			slp_cnt <= 32'h00000000;
		else if ((next_state == ST_SLEEP | next_state == ST_DEEP) & (state == ST_HALT))
			slp_cnt <= slp_time;
		else if ((state == ST_SLEEP | state == ST_DEEP) & (slp_cnt != 32'h00000000))
			slp_cnt <= slp_cnt - 32'h00000001; // [RULE_17]
	end

	// outputs follow the next state so they line up with the state register
	assign next_sleeping = (next_state == ST_SLEEP) | (next_state == ST_DEEP);
	assign next_cpu_on   = (next_state != ST_DISABLE) & ~next_sleeping;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpio_hiz                  <= 1'b0;
			always_on_domain_en       <= 1'b1;
			retention_ram_domain_en   <= 1'b0;
			cpu_minimal_domain_en     <= 1'b0;
			radio_domain_en           <= 1'b0;
			iram0_domain_en           <= 1'b0;
			iram1_domain_en           <= 1'b0;
			dram1_domain_en           <= 1'b0;
			otp_domain_en             <= 1'b0;
			data_ram_bank_zero_retain <= 1'b0;
			sysclk_sel_xtal           <= 1'b0;
			hf_xtal_en                <= 1'b0;
			pm_clk_slow               <= 1'b0;
			cpu_halt                  <= 1'b0;
		end else begin
			gpio_hiz                  <= next_state == ST_DISABLE; // [RULE_01]
			always_on_domain_en       <= 1'b1; // [RULE_05]
			retention_ram_domain_en   <= next_state != ST_DISABLE; // [RULE_06]
			cpu_minimal_domain_en     <= next_cpu_on; // [RULE_06]
			radio_domain_en           <= next_cpu_on & dom_reg[`PMRS_DOM_RADIO]; // [RULE_07]
			iram1_domain_en           <= next_cpu_on & dom_reg[`PMRS_DOM_IRAM1]; // [RULE_07]
			otp_domain_en             <= next_cpu_on & dom_reg[`PMRS_DOM_OTP]; // [RULE_07]
			iram0_domain_en           <= (next_state != ST_DISABLE) & dom_reg[`PMRS_DOM_IRAM0];
			dram1_domain_en           <= (next_state != ST_DISABLE) & dom_reg[`PMRS_DOM_DRAM1];
			data_ram_bank_zero_retain <= next_sleeping; // [RULE_19]
			sysclk_sel_xtal           <= next_state == ST_ACTIVE_XTAL; // [RULE_23]
			hf_xtal_en                <= next_state == ST_ACTIVE_XTAL; // [RULE_14]
			pm_clk_slow               <= next_sleeping; // [RULE_19]
			cpu_halt                  <= next_state == ST_HALT; // [RULE_15]
		end
	end

	// regulation matched to the detected configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dcdc_en           <= 1'b0;
			dcdc_step_up      <= 1'b0;
			dcdc_switch       <= 1'b0;
			ldo_vcc_en        <= 1'b0;
			vcc_charge_en     <= 1'b0;
			battery_side_supply_thresh_code <= 4'h0;
			vcc_thresh_code   <= 4'h0;
		end else begin
			dcdc_en      <= next_cpu_on & ((cfg == CFG_STEP_DOWN) | (cfg == CFG_STEP_UP)); // [RULE_19]
			dcdc_step_up <= cfg == CFG_STEP_UP; // [RULE_08]
			dcdc_switch  <= next_cpu_on & (((cfg == CFG_STEP_DOWN) & vcc_low_s)
				| ((cfg == CFG_STEP_UP) & battery_side_supply_low_s)); // [RULE_08]
			ldo_vcc_en   <= (cfg == CFG_DCDC_OFF) & (next_state != ST_DISABLE);
			vcc_charge_en <= (next_state == ST_SLEEP) ? mode_reg[`PMRS_MODE_VCCCHG]
				: next_cpu_on; // [RULE_18]
			battery_side_supply_thresh_code <= thr_reg[3:0]; // [RULE_10]
			vcc_thresh_code   <= thr_reg[7:4]; // [RULE_11]
		end
	end

	// low-frequency oscillators
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfrc_low_precision    <= 1'b0;
			lfrc_calib_en         <= 1'b0;
			lfx_amp_en            <= 1'b0;
			lfx_load_cap_en       <= 1'b0;
			lowfreq_crystal_clock <= 1'b0;
		end else begin
			lfrc_low_precision <= (next_state == ST_DEEP) | src_lfx; // [RULE_18] [RULE_20]
			lfrc_calib_en      <= mode_reg[`PMRS_MODE_CAL] & ~src_lfx; // [RULE_22]
			lfx_amp_en         <= (lfx_mode == 2'h1) | (lfx_mode == 2'h3); // [RULE_21]
			lfx_load_cap_en    <= lfx_mode == 2'h1; // [RULE_21]
			unique case (lfx_mode)
				2'h0: lowfreq_crystal_clock <= 1'b0; // [RULE_21]
				2'h2: lowfreq_crystal_clock <= osc_in_s;
				2'h1, 2'h3: lowfreq_crystal_clock <= amp_out_s;
			endcase
		end
	end

	property p_disable;
		@(posedge pclk) disable iff (!presetn)
		!en_s |=> (state == ST_DISABLE) && gpio_hiz ##1 !core_reset_n;
	endproperty
	a_disable: assert property (p_disable) else $error("disable not entered"); // [RULE_01]

	property p_soft_key;
		@(posedge pclk) disable iff (!presetn)
		soft_fire |=> !core_reset_n [*8];
	endproperty
	a_soft_key: assert property (p_soft_key) else $error("soft reset too short"); // [RULE_04]

	property p_wdog;
		@(posedge pclk) disable iff (!presetn)
		watchdog_req |=> !core_reset_n ##1 (rst_cnt != 6'h00);
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog reset missing"); // [RULE_03]

	property p_radio_dep;
		@(posedge pclk) disable iff (!presetn)
		(radio_domain_en || iram1_domain_en || otp_domain_en) |-> cpu_minimal_domain_en;
	endproperty
	a_radio_dep: assert property (p_radio_dep) else $error("domain on without minimal"); // [RULE_07]

	property p_wake;
		@(posedge pclk) disable iff (!presetn)
		((state == ST_SLEEP) && wake_s && en_s) |=> (state == ST_ACTIVE_RC) && !pm_clk_slow;
	endproperty
	a_wake: assert property (p_wake) else $error("pad wake ignored"); // [RULE_17]

	property p_sleep_outputs;
		@(posedge pclk) disable iff (!presetn)
		((state == ST_SLEEP) || (state == ST_DEEP)) |-> !dcdc_en && pm_clk_slow
			&& data_ram_bank_zero_retain && !cpu_minimal_domain_en;
	endproperty
	a_sleep_outputs: assert property (p_sleep_outputs) else $error("sleep outputs wrong"); // [RULE_19]

	property p_sleep_disabled;
		@(posedge pclk) disable iff (!presetn)
		((state == ST_HALT) && mode_reg[`PMRS_MODE_SLPDIS] && !wake_s && en_s)
			|=> (state == ST_HALT) && cpu_halt;
	endproperty
	a_sleep_disabled: assert property (p_sleep_disabled) else $error("slept while disabled"); // [RULE_16]

	property p_lfx_zero;
		@(posedge pclk) disable iff (!presetn)
		(lfx_mode == 2'h0) |=> !lowfreq_crystal_clock && !lfx_amp_en;
	endproperty
	a_lfx_zero: assert property (p_lfx_zero) else $error("crystal clock not held low"); // [RULE_21]

	property p_lv_event;
		@(posedge pclk) disable iff (!presetn)
		(battery_side_supply_low_s && !$past(battery_side_supply_low_s)) |=> lowvolt_event && lv_flags[0];
	endproperty
	a_lv_event: assert property (p_lv_event) else $error("low-voltage event missing"); // [RULE_09]

	property p_deep;
		@(posedge pclk) disable iff (!presetn)
		(state == ST_DEEP) |-> lfrc_low_precision && !vcc_charge_en && $past(state) != ST_SLEEP;
	endproperty
	a_deep: assert property (p_deep) else $error("deep sleep settings wrong"); // [RULE_18]

endmodule : pmrs_top

// ### sim/testbench.sv
// self-checking bench for the power mode and reset sequencer
// assumes pmrs_top with its APB slave and the defs header on the include path
`timescale 1ns/1ps
`include "pmrs_defs.svh"
module testbench import pmrs_pkg::*;;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, er, chip_enable_pin = 1, wake_pad = 0, vdd_low_cmp = 0;
	logic        battery_side_supply_below = 0, rf_supply_ok = 1, lowfreq_osc_input = 0, watchdog_req = 0;
	logic        core_reset_n, gpio_hiz, aon, ret, cpumin, radio, iram0, iram1, dram1, otp;
	logic        bank0, dcdc_en, vcc_charge_en, lowvolt_event, sysclk_sel_xtal, hf_xtal_en;
	logic        pm_clk_slow, lfrc_low_precision, lfrc_calib_en, lfclk;
	logic [3:0]  battery_side_supply_code, vcc_code;
	int          miscompares = 0, n_compared = 0, seen;
	always #12.5 pclk = ~pclk;
	pmrs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chip_enable_pin(chip_enable_pin), .wake_pad(wake_pad),
		.vdd_low_cmp(vdd_low_cmp), .battery_side_supply_below(battery_side_supply_below), .vcc_below(1'b0),
		.rf_supply_ok(rf_supply_ok), .det_battery_side_supply_hi(1'b1), .det_vcc_hi(1'b0),
		.det_sw_grounded(1'b0), .lowfreq_osc_input(lowfreq_osc_input),
		.lowfreq_amp_out(1'b0), .watchdog_req(watchdog_req), .core_reset_n(core_reset_n),
		.gpio_hiz(gpio_hiz), .always_on_domain_en(aon), .retention_ram_domain_en(ret),
		.cpu_minimal_domain_en(cpumin), .radio_domain_en(radio), .iram0_domain_en(iram0),
		.iram1_domain_en(iram1), .dram1_domain_en(dram1), .otp_domain_en(otp),
		.data_ram_bank_zero_retain(bank0), .dcdc_en(dcdc_en), .dcdc_step_up(),
		.dcdc_switch(), .ldo_vcc_en(), .vcc_charge_en(vcc_charge_en),
		.battery_side_supply_thresh_code(battery_side_supply_code), .vcc_thresh_code(vcc_code),
		.lowvolt_event(lowvolt_event), .sysclk_sel_xtal(sysclk_sel_xtal),
		.hf_xtal_en(hf_xtal_en), .pm_clk_slow(pm_clk_slow),
		.lfrc_low_precision(lfrc_low_precision), .lfrc_calib_en(lfrc_calib_en),
		.lfx_amp_en(), .lfx_load_cap_en(), .lowfreq_crystal_clock(lfclk), .cpu_halt());
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, g, x);
		end
	endtask
	// one APB transfer; rd and er carry the answer
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) miscompares++;
		rd = prdata;
		er = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task automatic ws(input logic [2:0] s);
		int n;
		n = 0;
		do begin
			apb(0, `PMRS_OFF_STAT, 0);
			n++;
		end while (rd[2:0] !== s && n < 3000);
		chk(rd[2:0], s);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask
	// a core reset cause: low within 3 cycles, stretched, then released
	task automatic rst_cause();
		cyc(3);
		chk(core_reset_n, 0);
		cyc(70);
		chk(core_reset_n, 1);
	endtask
	task automatic t_reset();
		ws(1);
		chk(rd[4:3], 0);
		apb(0, `PMRS_OFF_MODE, 0); chk(rd, 32'h00000050);
		apb(0, `PMRS_OFF_THR, 0); chk(rd, 32'h00000020);
		apb(0, `PMRS_OFF_DOM, 0); chk(rd, 32'h00000000);
		apb(0, 12'h01C, 0); chk({er, rd}, {1'b1, 32'h0});
		cyc(50);
		chk({aon, lfrc_calib_en, lfclk, dcdc_en, core_reset_n}, 5'h1B);
		$display("reset test done");
	endtask
	task automatic t_regs();
		apb(1, `PMRS_OFF_THR, 32'h0000002A); cyc(2);
		chk({vcc_code, battery_side_supply_code}, 8'h2A);
		apb(1, `PMRS_OFF_DOM, 32'h0000001F); cyc(2);
		chk({radio, iram0, iram1, dram1, otp, cpumin, ret}, 7'h7F);
		apb(1, `PMRS_OFF_MODE, 32'h00000058); ws(2);
		chk({sysclk_sel_xtal, hf_xtal_en}, 2'h3);
		apb(1, `PMRS_OFF_MODE, 32'h00000050); ws(1);
		chk(sysclk_sel_xtal, 0);
		$display("register test done");
	endtask
	task automatic t_lfx();
		apb(1, `PMRS_OFF_MODE, 32'h00000052);
		lowfreq_osc_input <= 1; cyc(5); chk(lfclk, 1);
		@(posedge pclk);
		lowfreq_osc_input <= 0; cyc(5); chk(lfclk, 0);
		apb(1, `PMRS_OFF_MODE, 32'h00000050);
		lowfreq_osc_input <= 1; cyc(5); chk(lfclk, 0);
		@(posedge pclk);
		lowfreq_osc_input <= 0;
		$display("crystal mode test done");
	endtask
	task automatic t_sleep();
		apb(1, `PMRS_OFF_SLPT, 32'd5000);
		apb(1, `PMRS_OFF_CMD, 32'h00000003); cyc(3);
		chk({pm_clk_slow, dcdc_en, cpumin, radio, bank0, vcc_charge_en}, 6'h23);
		ws(1);
		apb(1, `PMRS_OFF_SLPT, 32'd100);
		apb(1, `PMRS_OFF_CMD, 32'h00000003); cyc(30);
		ws(3);
		wake_pad <= 1; ws(1); wake_pad <= 0;
		apb(1, `PMRS_OFF_MODE, 32'h00000054);
		apb(1, `PMRS_OFF_SLPT, 32'd5000);
		apb(1, `PMRS_OFF_CMD, 32'h00000003); cyc(30);
		ws(3);
		wake_pad <= 1; ws(1); wake_pad <= 0;
		apb(1, `PMRS_OFF_MODE, 32'h00000050);
		apb(1, `PMRS_OFF_SLPT, 32'd0);
		apb(1, `PMRS_OFF_CMD, 32'h00000005); ws(5);
		chk({vcc_charge_en, lfrc_low_precision, dcdc_en, pm_clk_slow}, 4'h5);
		wake_pad <= 1; ws(1); wake_pad <= 0;
		$display("sleep test done");
	endtask
	task automatic t_resets();
		apb(1, `PMRS_OFF_SRST, `PMRS_KEY_FIRST);
		apb(0, `PMRS_OFF_STAT, 0); chk(rd[9], 1);
		apb(1, `PMRS_OFF_SRST, 32'h00000000);
		apb(1, `PMRS_OFF_SRST, `PMRS_KEY_SECOND); cyc(3);
		chk(core_reset_n, 1);
		apb(1, `PMRS_OFF_SRST, `PMRS_KEY_FIRST);
		apb(1, `PMRS_OFF_SRST, `PMRS_KEY_SECOND);
		rst_cause();
		@(posedge pclk);
		watchdog_req <= 1; @(posedge pclk); watchdog_req <= 0;
		rst_cause();
		@(posedge pclk);
		vdd_low_cmp <= 1; @(posedge pclk); vdd_low_cmp <= 0;
		rst_cause();
		cyc(50);
		$display("reset cause test done");
	endtask
	task automatic t_lowv();
		seen = 0;
		@(posedge pclk);
		battery_side_supply_below <= 1;
		repeat (8) begin
			@(negedge pclk);
			seen += int'(lowvolt_event === 1'b1);
		end
		chk(seen, 1);
		apb(0, `PMRS_OFF_STAT, 0); chk(rd[5], 1);
		battery_side_supply_below <= 0; cyc(4);
		apb(1, `PMRS_OFF_STAT, 32'h00000020);
		apb(0, `PMRS_OFF_STAT, 0); chk(rd[5], 0);
		rf_supply_ok <= 0; cyc(5);
		apb(0, `PMRS_OFF_STAT, 0); chk({rd[8], rd[7]}, 2'b01);
		rf_supply_ok <= 1;
		$display("low voltage test done");
	endtask
	task automatic t_disable();
		apb(1, `PMRS_OFF_DOM, 32'h0000001F);
		chip_enable_pin <= 0; cyc(5);
		chk({gpio_hiz, core_reset_n, radio}, 3'h4);
		chip_enable_pin <= 1; ws(1);
		apb(0, `PMRS_OFF_DOM, 0); chk(rd, 0);
		chk(gpio_hiz, 0);
		$display("chip disable test done");
	endtask
	task automatic summarize();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#(25 * 80000);
		miscompares++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		t_reset(); t_regs(); t_lfx(); t_sleep(); t_resets(); t_lowv(); t_disable();
		summarize();
	end
endmodule // testbench
